// ### gtc_timer_core.sv
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
// Function
// - every odd timer instance gets one identical copy of this module.
// - sixteen-bit up-counter; software count writes replace the value at once.
// - instruction-cycle source counts once per instruction cycle, after the prescaler.
// - external sources count on each selected edge, as timer or counter.
// - off when on is 0; free when gate enable 0; else gated.
// - a multi-bit select picks sync or async counting clock sources.
// - undivided oscillator source advances four counts per instruction cycle.
// - counter mode needs a falling edge before first rising edge counts.
// - pin source counts rising edges, synchronized or unsynchronized.
// - selected clock divided by 1, 2, 4 or 8 from two-bit field.
// - prescale counter hidden from software, cleared by any count write.
// - synchronizer stops in sleep; only unsynchronized paths count then.
// - shared slow crystal oscillator selectable as source, runs in sleep.
// - sync bypass set: input not synchronized, counts asynchronously.
// - count rolls FFFF to 0000 and sets the rollover flag.
// - gated mode counts only while gate level equals polarity setting.
module gtc_timer_core #(
    parameter int ADDR_WIDTH = 12
) (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst,
    // apb slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [ADDR_WIDTH-1:0]   paddr,
    input  wire logic [31:0]             pwdata,
    input  wire logic [3:0]              pstrb,
    output logic [31:0]                  prdata,
    output logic                         pready,
    output logic                         pslverr,
    // counting clock sources and gate
    input  wire gtc_pkg::gtc_clk_in_type clkIn,
    input  wire logic                    slowOscReady,
    input  wire logic                    gateSignal,
    input  wire logic                    sleepMode,
    // block outputs
    output logic [15:0]                  countValue,
    output logic                         rolloverFlag,
    output logic                         rolloverPulse,
    output logic                         secondaryOscEnable
);
    import gtc_pkg::*;

    gtc_ctrl_type ctrl;
    logic [15:0]  countPair;
    logic [2:0]   prescaleCount;
    logic [1:0]   instrPhase;
    logic         syncStage1;
    logic         syncStage2;
    logic         prevLevel;
    logic         armed;
    logic         rollover;
    logic         rollPulse;
    logic [31:0]  readData;
    logic         readErr;

    // prescaler terminal mask for 1, 2, 4 or 8
    function automatic logic [2:0] prescaleMask(input logic [1:0] ratio);
        logic [2:0] mask;
        mask = 3'h0;
        case (ratio)
            2'h0: mask = 3'h0;
            2'h1: mask = 3'h1;
            2'h2: mask = 3'h3;
            default: mask = 3'h7;
        endcase
        return mask;
    endfunction

    // level of the selected edge-type source
    function automatic logic sourceLevel(input logic [2:0] src, input gtc_clk_in_type ins);
        logic lvl;
        lvl = 1'b0;
        case (src)
            SRC_PIN:      lvl = ins.extClockPin;
            SRC_SLOW_OSC: lvl = ins.slowCrystalOsc;
            default:      lvl = ins.auxClock[src[1:0]];
        endcase
        return lvl;
    endfunction

    // bus decode
    wire setupPhase = psel & ~penable;
    wire accessPhase = psel & penable;
    wire busWrite = accessPhase & pwrite;
    wire [11:0] regAddr = 12'(paddr);
    wire hitCtrl = (regAddr == CTRL_OFFSET);
    wire hitPair = (regAddr == COUNT_PAIR_OFFSET);
    wire hitStatus = (regAddr == STATUS_OFFSET);
    wire hitLow = (regAddr == COUNT_LOW_OFFSET);
    wire hitHigh = (regAddr == COUNT_HIGH_OFFSET);
    wire hitAny = hitCtrl | hitPair | hitStatus | hitLow | hitHigh;

    wire wrCtrlLow = busWrite & hitCtrl & pstrb[0];
    wire wrCtrlHigh = busWrite & hitCtrl & pstrb[1];
    wire wrLowByte = busWrite & ((hitPair & pstrb[0]) | (hitLow & pstrb[0]));
    wire wrHighByte = busWrite & ((hitPair & pstrb[1]) | (hitHigh & pstrb[0]));
    wire [7:0] highByteData = hitHigh ? pwdata[7:0] : pwdata[15:8];
    wire countWrite = wrLowByte | wrHighByte;
    wire clearRoll = busWrite & hitStatus & pstrb[0] & pwdata[STAT_ROLLOVER_BIT];

    // source classification
    wire [2:0] src = ctrl.clockSource;
    wire internalSrc = (src == SRC_INSTR) | (src == SRC_FOSC);
    wire rawLevel = sourceLevel(src, clkIn);

    // bypass feeds raw level straight to the edge detector
    wire curLevel = ctrl.syncBypass ? rawLevel : syncStage2;
    wire riseEdge = curLevel & ~prevLevel;
    wire fallEdge = ~curLevel & prevLevel;

    // synchronized paths are frozen while asleep
    wire syncBlocked = sleepMode & ~ctrl.syncBypass;
    wire extActive = ~internalSrc & ~syncBlocked;

    // internal tick: fosc every clock (four per instruction), else once on the last phase
    wire instrTick = (instrPhase == PHASE_LAST);
    wire internalTick = (src == SRC_FOSC) ? 1'b1 : instrTick;

    // rising edge counts only once armed by a falling edge
    wire extTick = extActive & riseEdge & armed;
    wire srcPulse = internalSrc ? (internalTick & ~sleepMode) : extTick;

    // enable truth: off, free running, or gated by polarity
    wire gateOpen = (gateSignal == ctrl.gatePolarity);
    wire countEnable = ctrl.on & (~ctrl.gateEnable | gateOpen);

    // prescaler terminal count
    wire [2:0] mask = prescaleMask(ctrl.prescaleRatio);
    wire prescaleDone = ((prescaleCount & mask) == mask);
    wire advance = srcPulse & countEnable;
    wire countStep = advance & prescaleDone;
    wire wrapNow = countStep & (countPair == COUNT_MAX);

    wire [2:0] next_prescaleCount = prescaleDone ? PRESCALE_RESET : prescaleCount + 3'h1;
    wire [15:0] next_countPair = countPair + 16'h0001;

    // read mux, unused bits read as zero
    wire [31:0] ctrlWord = {{(32 - CTRL_WIDTH){1'b0}}, ctrl};
    wire [31:0] statusWord = {28'h0000000, armed, gateSignal, slowOscReady, rollover};
    assign readData = hitCtrl   ? ctrlWord :
                      hitPair   ? {16'h0000, countPair} :
                      hitStatus ? statusWord :
                      hitLow    ? {24'h000000, countPair[7:0]} :
                      hitHigh   ? {24'h000000, countPair[15:8]} : READ_ZERO;
    assign readErr = ~hitAny;

    // zero-wait slave
    assign pready = 1'b1;

    // control register, byte lane writes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl <= CTRL_RESET;
        end else begin
            if (wrCtrlLow) begin
                ctrl.clockSource <= pwdata[CTRL_SOURCE_LSB +: 3];
                ctrl.prescaleRatio <= pwdata[CTRL_PRESCALE_LSB +: 2];
                ctrl.secondaryOscEnable <= pwdata[CTRL_OSC_EN_BIT];
                ctrl.syncBypass <= pwdata[CTRL_BYPASS_BIT];
                ctrl.gatePolarity <= pwdata[CTRL_POLARITY_BIT];
            end
            if (wrCtrlHigh) begin
                ctrl.gateEnable <= pwdata[CTRL_GATE_EN_BIT];
                ctrl.on <= pwdata[CTRL_ON_BIT];
            end
        end
    end

    // instruction phase, divides clk by four
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            instrPhase <= PHASE_RESET;
        end else begin
            instrPhase <= instrPhase + 2'h1;
        end
    end

    // two-stage synchronizer, first stage read only by the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            syncStage1 <= 1'b0;
            syncStage2 <= 1'b0;
        end else if (!syncBlocked) begin
            syncStage1 <= rawLevel;
            syncStage2 <= syncStage1;
        end
    end

    // edge history; switching sync mode may skip or add one increment
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prevLevel <= 1'b0;
        end else if (!syncBlocked) begin
            prevLevel <= curLevel;
        end
    end

    // falling-edge arming, dropped on disable or count write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            armed <= 1'b0;
        end else if (!ctrl.on || countWrite) begin
            armed <= 1'b0;
        end else if (extActive && fallEdge) begin
            armed <= 1'b1;
        end
    end

    // prescale counter, not visible on the bus
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prescaleCount <= PRESCALE_RESET;
        end else if (countWrite) begin
            prescaleCount <= PRESCALE_RESET;
        end else if (advance) begin
            prescaleCount <= next_prescaleCount;
        end
    end

    // one self-contained copy per odd timer instance
    // software write wins over a same-cycle increment
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            countPair <= COUNT_RESET;
        end else if (countWrite) begin
            if (wrLowByte) begin
                countPair[7:0] <= pwdata[7:0];
            end
            if (wrHighByte) begin
                countPair[15:8] <= highByteData;
            end
        end else if (countStep) begin
            countPair <= next_countPair;
        end
    end

    // rollover flag, set beats a same-cycle clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rollover <= 1'b0;
            rollPulse <= 1'b0;
        end else begin
            rollPulse <= wrapNow;
            if (wrapNow) begin
                rollover <= 1'b1;
            end else if (clearRoll) begin
                rollover <= 1'b0;
            end
        end
    end

    // read data captured in setup so the access cycle answers at once
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata <= READ_ZERO;
            pslverr <= 1'b0;
        end else if (setupPhase) begin
            prdata <= pwrite ? READ_ZERO : readData;
            pslverr <= readErr;
        end
    end

    // oscillator enable leaves the block; ready is polled by software
    assign secondaryOscEnable = ctrl.secondaryOscEnable;
    assign countValue = countPair;
    assign rolloverFlag = rollover;
    assign rolloverPulse = rollPulse;

endmodule

// ### gtc_pkg.sv
package gtc_pkg;

    // register byte offsets on the 32-bit bus
    localparam logic [11:0] CTRL_OFFSET       = 12'h000;
    localparam logic [11:0] COUNT_PAIR_OFFSET = 12'h004;
    localparam logic [11:0] STATUS_OFFSET     = 12'h008;
    localparam logic [11:0] COUNT_LOW_OFFSET  = 12'h00C;
    localparam logic [11:0] COUNT_HIGH_OFFSET = 12'h010;

    // control word field positions
    localparam int CTRL_SOURCE_LSB   = 0;
    localparam int CTRL_PRESCALE_LSB = 3;
    localparam int CTRL_OSC_EN_BIT   = 5;
    localparam int CTRL_BYPASS_BIT   = 6;
    localparam int CTRL_POLARITY_BIT = 7;
    localparam int CTRL_GATE_EN_BIT  = 8;
    localparam int CTRL_ON_BIT       = 9;
    localparam int CTRL_WIDTH        = 10;

    // status word field positions
    localparam int STAT_ROLLOVER_BIT  = 0;
    localparam int STAT_OSC_READY_BIT = 1;
    localparam int STAT_GATE_BIT      = 2;
    localparam int STAT_ARMED_BIT     = 3;

    // reset values and terminal values
    localparam logic [15:0] COUNT_RESET    = 16'h0000;
    localparam logic [15:0] COUNT_MAX      = 16'hFFFF;
    localparam logic [2:0]  PRESCALE_RESET = 3'h0;
    localparam logic [1:0]  PHASE_RESET    = 2'h0;
    localparam logic [1:0]  PHASE_LAST     = 2'h3;
    localparam logic [31:0] READ_ZERO      = 32'h0000_0000;

    // clock source select codes
    localparam logic [2:0] SRC_INSTR    = 3'h0;
    localparam logic [2:0] SRC_FOSC     = 3'h1;
    localparam logic [2:0] SRC_PIN      = 3'h2;
    localparam logic [2:0] SRC_SLOW_OSC = 3'h3;
    localparam logic [2:0] SRC_AUX0     = 3'h4;

    typedef struct packed {
        logic       on;
        logic       gateEnable;
        logic       gatePolarity;
        logic       syncBypass;
        logic       secondaryOscEnable;
        logic [1:0] prescaleRatio;
        logic [2:0] clockSource;
    } gtc_ctrl_type;

    localparam gtc_ctrl_type CTRL_RESET = '0;

    typedef struct packed {
        logic extClockPin;
        logic slowCrystalOsc;
        logic [3:0] auxClock;
    } gtc_clk_in_type;

endpackage

// ### gtc_timer_core_checker.sv
`timescale 1ns/1ps
module gtc_timer_core_checker #(
    parameter int ADDR_WIDTH = 12
) (
    // clock and reset
    input wire logic                  clk,
    input wire logic                  rst,
    // bus
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0]           pwdata,
    input wire logic [3:0]            pstrb,
    input wire logic                  pslverr,
    // count side
    input wire logic                  gateSignal,
    input wire logic                  sleepMode,
    input wire logic [15:0]           countValue,
    input wire logic                  rolloverFlag,
    input wire logic                  rolloverPulse
);
    import gtc_pkg::*;
    logic [CTRL_WIDTH-1:0] shCtrl;
    wire apbWr = psel && penable && pwrite;
    wire [15:0] pwLow = pwdata[15:0];
    wire shOn = shCtrl[CTRL_ON_BIT];
    wire shGate = shCtrl[CTRL_GATE_EN_BIT];
    wire fastRun = shOn && !shGate && shCtrl[4:0] == {2'h0, SRC_FOSC} && !sleepMode && !apbWr;
    wire gateOff = shOn && shGate && gateSignal != shCtrl[CTRL_POLARITY_BIT] && !apbWr;
    wire mapped = paddr inside {CTRL_OFFSET, COUNT_PAIR_OFFSET, STATUS_OFFSET,
                                COUNT_LOW_OFFSET, COUNT_HIGH_OFFSET};
    // control shadow rebuilt from bus writes, lanes honoured
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shCtrl <= '0;
        end else if (apbWr && paddr == CTRL_OFFSET) begin
            shCtrl <= {pstrb[1] ? pwdata[9:8] : shCtrl[9:8], pstrb[0] ? pwdata[7:0] : shCtrl[7:0]};
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence wrap_seq;
        countValue == COUNT_RESET && $past(countValue) == COUNT_MAX && !$past(apbWr);
    endsequence
    // gate held three samples so a registered gate cannot blur the edge
    sequence gate_steady_seq;
        gateOff && $past(gateSignal) == gateSignal && $past(gateSignal, 2) == gateSignal;
    endsequence
    chk_reset_clear: assert property ($fell(rst) |-> countValue == COUNT_RESET && !rolloverFlag)
        else $error("count or flag not cleared by reset");
    chk_single_step: assert property (!$past(apbWr) |->
        countValue == $past(countValue) || countValue == $past(countValue) + 16'h0001)
        else $error("count moved by more than one");
    chk_write_load: assert property (apbWr && paddr == COUNT_PAIR_OFFSET && pstrb == 4'hF
        |=> countValue == $past(pwLow)) else $error("count write not taken");
    chk_wrap_flag: assert property (wrap_seq |-> ##[0:1] (rolloverPulse && rolloverFlag))
        else $error("wrap without flag and pulse");
    chk_pulse_once: assert property (rolloverPulse |=> !rolloverPulse)
        else $error("rollover pulse longer than one cycle");
    chk_flag_sticky: assert property ($fell(rolloverFlag) |-> $past(apbWr))
        else $error("flag dropped without a write");
    chk_off_hold: assert property (!shOn && !apbWr |=> $stable(countValue))
        else $error("count moved while off");
    chk_fast_step: assert property (fastRun |=> countValue == $past(countValue) + 16'h0001)
        else $error("fast source missed a step");
    chk_gate_hold: assert property (gate_steady_seq |=> $stable(countValue))
        else $error("count moved with gate inactive");
    chk_unmapped_err: assert property (psel && !penable && !mapped |=> pslverr)
        else $error("no error on unmapped access");
endmodule

bind gtc_timer_core gtc_timer_core_checker #(.ADDR_WIDTH(ADDR_WIDTH)) chk_u (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pslverr(pslverr), .gateSignal(gateSignal),
    .sleepMode(sleepMode), .countValue(countValue), .rolloverFlag(rolloverFlag),
    .rolloverPulse(rolloverPulse));

// ### gtc_timer_core_test.sv
`timescale 1ns/1ps
module gtc_timer_core_test;
    import gtc_pkg::*;
    logic           clk = 1'b0;
    logic           rst = 1'b1;
    logic           psel = 1'b0;
    logic           penable = 1'b0;
    logic           pwrite = 1'b0;
    logic [11:0]    paddr = 12'h000;
    logic [31:0]    pwdata = 32'h0000_0000;
    logic [3:0]     pstrb = 4'hF;
    logic           lvl = 1'b1;
    logic           gateSignal = 1'b0;
    logic           sleepMode = 1'b0;
    logic           oscReady = 1'b0;
    logic           oscEn;
    logic [31:0]    prdata;
    logic           pready;
    logic           pslverr;
    logic [15:0]    countValue;
    logic [15:0]    rv;
    logic [32:0]    expQ[$];
    gtc_clk_in_type clkIn;
    int             fails = 0;
    int             num_checks = 0;
    int             seed = 4358;
    // one level feeds every edge source, so each select sees the same pulses
    assign clkIn = {lvl, lvl, {4{lvl}}};
    gtc_timer_core #(.ADDR_WIDTH(12)) dut_u (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .clkIn(clkIn), .slowOscReady(oscReady), .gateSignal(gateSignal),
        .sleepMode(sleepMode), .countValue(countValue), .rolloverFlag(),
        .rolloverPulse(), .secondaryOscEnable(oscEn));
    initial forever #12.5 clk = ~clk;
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input logic [32:0] seen, input logic [32:0] want);
        num_checks++;
        if (seen !== want) begin
            fails++;
            $display("wrong value at %0t: got %h want %h", $time, seen, want);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hF);
    endtask
    task automatic rd(input logic [11:0] a, input logic [32:0] want);
        expQ.push_back(want);
        bus(1'b0, a, 32'h0, 4'hF);
    endtask
    // load, run 64 edges, stop, read; edge sources toggle only early so sync lag settles
    task automatic run(input logic [15:0] st, input logic [9:0] cw, input logic lv,
                       input logic slp, input logic [15:0] ex);
        lvl <= lv;
        sleepMode <= slp;
        repeat (4) @(posedge clk);
        wr(COUNT_PAIR_OFFSET, {16'h0, st});
        wr(CTRL_OFFSET, {22'h0, cw});
        for (int i = 0; i < 61; i++) begin
            @(posedge clk);
            if (i % 4 == 3 && i < 48 && cw[2:0] >= SRC_PIN) lvl <= !lvl;
        end
        wr(CTRL_OFFSET, 32'h0);
        sleepMode <= 1'b0;
        rd(COUNT_PAIR_OFFSET, {17'h0, ex});
    endtask
    // control reads also compare the oscillator enable pin against the noted word
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (paddr == CTRL_OFFSET) begin
                check({32'h0, oscEn}, {32'h0, expQ[0][CTRL_OSC_EN_BIT]});
            end
            check({pslverr, prdata}, expQ.pop_front());
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd(CTRL_OFFSET, 33'h0);
        rd(COUNT_PAIR_OFFSET, 33'h0);
        rd(STATUS_OFFSET, 33'h0);
        rd(12'h014, 33'h1_0000_0000);
        wr(COUNT_PAIR_OFFSET, 32'h1234);
        bus(1'b1, COUNT_PAIR_OFFSET, 32'hFFAB, 4'h1);
        wr(COUNT_HIGH_OFFSET, 32'h56);
        rd(COUNT_PAIR_OFFSET, 33'h56AB);
        repeat (3) begin
            rv = 16'($random(seed));
            wr(COUNT_PAIR_OFFSET, {16'h0, rv});
            rd(COUNT_PAIR_OFFSET, {17'h0, rv});
        end
        run(16'h0000, 10'h201, 1'b1, 1'b0, 16'h0040);
        run(16'h0000, 10'h209, 1'b1, 1'b0, 16'h0020);
        run(16'h0000, 10'h211, 1'b1, 1'b0, 16'h0010);
        run(16'h0000, 10'h219, 1'b1, 1'b0, 16'h0008);
        run(16'h0100, 10'h200, 1'b1, 1'b0, 16'h0110);
        run(16'h0005, 10'h001, 1'b1, 1'b0, 16'h0005);
        run(16'h0000, 10'h381, 1'b1, 1'b0, 16'h0000);
        run(16'h0000, 10'h301, 1'b1, 1'b0, 16'h0040);
        // gate is a plain level, never a synced gate over a synced clock
        gateSignal <= 1'b1;
        run(16'h0000, 10'h381, 1'b1, 1'b0, 16'h0040);
        rd(STATUS_OFFSET, 33'h4);
        gateSignal <= 1'b0;
        run(16'h0000, 10'h201, 1'b1, 1'b1, 16'h0000);
        run(16'h0000, 10'h202, 1'b1, 1'b0, 16'h0006);
        run(16'h0000, 10'h202, 1'b0, 1'b0, 16'h0005);
        run(16'h0000, 10'h242, 1'b0, 1'b0, 16'h0005);
        wr(CTRL_OFFSET, 32'h20);
        oscReady <= 1'b1;
        rd(STATUS_OFFSET, 33'h2);
        rd(CTRL_OFFSET, 33'h20);
        run(16'h0000, 10'h263, 1'b1, 1'b1, 16'h0006);
        run(16'h0000, 10'h244, 1'b1, 1'b0, 16'h0006);
        run(16'hFFFE, 10'h201, 1'b1, 1'b0, 16'h003E);
        rd(STATUS_OFFSET, 33'h3);
        wr(STATUS_OFFSET, 32'h1);
        rd(STATUS_OFFSET, 33'h2);
        tally_and_finish();
    end
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        tally_and_finish();
    end
endmodule
